// ===== design/asr_host.sv
`timescale 1ns/1ns
`default_nettype none
module asr_host #(
	parameter int POWER_UP_CYCLES = asr_pkg::POWER_UP_CYC
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire asr_pkg::asr_req_t REQ,
	output logic RSP_VALID,
	output logic [asr_pkg::DATA_W-1:0] RSP_DATA,
	input wire logic RETAIN_REQ,
	output logic RETAIN_OK,
	output logic POWER_READY,
	output asr_pkg::asr_pins_t PINS,
	input wire logic [asr_pkg::DATA_W-1:0] DQ_I,
	output logic [asr_pkg::DATA_W-1:0] DQ_O,
	output logic [asr_pkg::DATA_W-1:0] DQ_OE
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {ST_ARM, ST_POWER, ST_IDLE, ST_READ, ST_CAPTURE, ST_WRITE, ST_TURN,
		ST_RETAIN} asr_state_t;
	asr_state_t state;
	asr_state_t next_state;
	asr_pkg::asr_req_t cur;
	logic [asr_pkg::DATA_W-1:0] dq_meta;
	logic [asr_pkg::DATA_W-1:0] dq_sync;
	logic wait_load;
	logic [asr_pkg::CNT_W-1:0] wait_value;
	logic wait_done;
	logic [asr_pkg::LANES-1:0] lane_n;
	logic take;
	asr_pkg::asr_pins_t next_pins;
	logic [asr_pkg::CNT_W-1:0] power_cnt;

	// Shared down-counter for every timed interval
	asr_wait #(.W(asr_pkg::CNT_W)) u_wait (
		.SYS_CLK(SYS_CLK),
		.NRST(NRST),
		.load(wait_load),
		.value(wait_value),
		.done(wait_done)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Requests with no lane are left waiting, never taken
	assign take = (state == ST_IDLE) && REQ_VALID && !RETAIN_REQ && (REQ.lanes != '0);
	assign REQ_READY = (state == ST_IDLE) && !RETAIN_REQ;
	assign lane_n = ~cur.lanes;
	assign RETAIN_OK = (state == ST_RETAIN) && PINS.select_n;
	assign POWER_READY = (state != ST_ARM) && (state != ST_POWER);

	always_comb begin
		next_state = state;
		wait_load = 1'b0;
		wait_value = '0;
		case (state)
			ST_ARM: begin
				wait_load = 1'b1;
				wait_value = asr_pkg::CNT_W'(POWER_UP_CYCLES - 1);
				next_state = ST_POWER;
			end
			ST_POWER: if (wait_done) next_state = ST_IDLE;
			ST_IDLE: begin
				if (RETAIN_REQ) begin
					next_state = ST_RETAIN;
				end else if (take) begin
					wait_load = 1'b1;
					// Read: two spare cycles, pins launch just after the edge
					wait_value = REQ.write ? asr_pkg::CNT_W'(asr_pkg::WRITE_CYC - 1)
						: asr_pkg::CNT_W'(asr_pkg::READ_CYC + 1);
					next_state = REQ.write ? ST_WRITE : ST_READ;
				end
			end
			ST_READ: if (wait_done) next_state = ST_CAPTURE;
			ST_CAPTURE: begin
				wait_load = 1'b1;
				wait_value = asr_pkg::CNT_W'(asr_pkg::TURN_CYC - 1);
				next_state = ST_TURN;
			end
			ST_WRITE: begin
				if (wait_done) begin
					wait_load = 1'b1;
					wait_value = asr_pkg::CNT_W'(asr_pkg::TURN_CYC - 1);
					next_state = ST_TURN;
				end
			end
			ST_TURN: if (wait_done) next_state = ST_IDLE;
			ST_RETAIN: if (!RETAIN_REQ) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// Registered strobes; address and data set with the strobes and held through the end
	always_comb begin
		next_pins = asr_pkg::PINS_IDLE;
		next_pins.addr = PINS.addr;
		if (take) begin
			next_pins.addr = REQ.addr;
			next_pins.select_n = 1'b0;
			next_pins.write_strobe_n = !REQ.write;
			next_pins.out_drive_n = REQ.write;
			next_pins.upper_lane_enable_n = !REQ.lanes[1];
			next_pins.lower_lane_enable_n = !REQ.lanes[0];
		end else if ((state == ST_READ) || (state == ST_WRITE && !wait_done)) begin
			next_pins = PINS;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			state <= ST_ARM;
			PINS <= asr_pkg::PINS_IDLE;
		end else begin
			state <= next_state;
			PINS <= next_pins;
		end
	end

	// Write data and drive enables launch with the strobes
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			cur <= '0;
			DQ_O <= '0;
			DQ_OE <= '0;
		end else if (take) begin
			cur <= REQ;
			DQ_O <= REQ.wdata;
			for (int i = 0; i < asr_pkg::LANES; i++)
				DQ_OE[i*asr_pkg::LANE_W +: asr_pkg::LANE_W] <= {asr_pkg::LANE_W{REQ.write && REQ.lanes[i]}};
		end else if (state == ST_TURN) begin
			DQ_OE <= '0;
		end
	end

	// Data pins pass two flops before use
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			dq_meta <= '0;
			dq_sync <= '0;
		end else begin
			dq_meta <= DQ_I;
			dq_sync <= dq_meta;
		end
	end

	// Disabled lanes read as zero
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			RSP_VALID <= 1'b0;
			RSP_DATA <= '0;
		end else begin
			RSP_VALID <= (state == ST_CAPTURE);
			if (state == ST_CAPTURE) begin
				for (int i = 0; i < asr_pkg::LANES; i++)
					RSP_DATA[i*asr_pkg::LANE_W +: asr_pkg::LANE_W] <= lane_n[i] ?
						'0 : dq_sync[i*asr_pkg::LANE_W +: asr_pkg::LANE_W];
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Cycles since reset release, held at its ceiling
	always_ff @(posedge SYS_CLK) begin
		if (!NRST)
			power_cnt <= '0;
		else if (power_cnt != '1)
			power_cnt <= power_cnt + 1'b1;
	end

	AST_WE_HIGH_IN_READ: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!PINS.out_drive_n |-> PINS.write_strobe_n) else $error("write strobe low in read");
	AST_NO_ACCESS_POWER: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(state == ST_ARM || state == ST_POWER) |-> PINS.select_n) else $error("access in power wait");
	AST_POWER_COUNT: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$fell(PINS.select_n) |-> (power_cnt >= asr_pkg::CNT_W'(POWER_UP_CYCLES)))
		else $error("access before power count");
	AST_WRITE_HELD: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$fell(PINS.write_strobe_n) |-> !PINS.select_n && (DQ_OE != '0)
			&& !(PINS.upper_lane_enable_n && PINS.lower_lane_enable_n))
		else $error("write strobes not low together");
	AST_ADDR_STABLE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(!PINS.select_n && !$fell(PINS.select_n)) |-> $stable(PINS.addr))
		else $error("address moved in access");
	AST_ADDR_AT_SELECT: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$fell(PINS.select_n) |-> (PINS.addr == cur.addr))
		else $error("address late at select");
	AST_DATA_HOLD: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$rose(PINS.write_strobe_n) |-> (DQ_OE != '0) && $stable(DQ_O))
		else $error("write data not held");
	AST_DATA_SETUP: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$rose(PINS.write_strobe_n) |-> ($past(DQ_OE) != '0)) else $error("write data late");
	AST_DATA_RELEASE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$rose(PINS.write_strobe_n) |=> (DQ_OE == '0)) else $error("data bus not released");
	AST_RETAIN_DESEL: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(state == ST_RETAIN) |-> PINS.select_n) else $error("selected in retention");
	AST_OE_XOR_DRIVE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!PINS.out_drive_n |-> (DQ_OE == '0)) else $error("bus fight");
	AST_READ_RESP: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$fell(PINS.out_drive_n) |-> ##4 RSP_VALID) else $error("read response late");
	AST_READ_HOLD: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		$fell(PINS.out_drive_n) |-> !PINS.out_drive_n [*4]) else $error("read window short");
	AST_LANE_STROBE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!PINS.select_n |-> !(PINS.upper_lane_enable_n && PINS.lower_lane_enable_n))
		else $error("access with no lane");
	CV_READ: cover property (@(posedge SYS_CLK) RSP_VALID);
	CV_WRITE: cover property (@(posedge SYS_CLK) $rose(PINS.write_strobe_n));
	CV_RETAIN: cover property (@(posedge SYS_CLK) RETAIN_OK);
	CV_POWER: cover property (@(posedge SYS_CLK) $rose(POWER_READY));
	CV_ONE_LANE: cover property (@(posedge SYS_CLK) !PINS.select_n && PINS.upper_lane_enable_n);
endmodule
`default_nettype wire

// ===== include/asr_pkg.sv
package asr_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int POWER_UP_WAIT_US = 100;
	localparam int ADDR_TO_VALID_TIME_NS = 10;
	localparam int OE_TO_VALID_NS = 5;
	localparam int LANE_TO_WRITE_END_NS = 7;
	localparam int WRITE_DATA_SETUP_NS = 6;
	localparam int BUS_TURN_NS = 5;
	// Least times round up; read, write and turn cycle counts are at least one
	localparam int POWER_UP_CYC = (POWER_UP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC_RAW = (ADDR_TO_VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = (READ_CYC_RAW < 1) ? 1 : READ_CYC_RAW;
	localparam int WRITE_CYC_RAW = (LANE_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC = (WRITE_CYC_RAW < 1) ? 1 : WRITE_CYC_RAW;
	localparam int TURN_CYC_RAW = (BUS_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC = (TURN_CYC_RAW < 1) ? 1 : TURN_CYC_RAW;
	localparam int CNT_W = 16;
	localparam logic [LANES-1:0] LANES_OFF = 2'h3;
	// Pin group driven toward the memory, all strobes active low
	typedef struct packed {
		logic select_n;
		logic out_drive_n;
		logic write_strobe_n;
		logic upper_lane_enable_n;
		logic lower_lane_enable_n;
		logic [ADDR_W-1:0] addr;
	} asr_pins_t;
	localparam asr_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
	typedef struct packed {
		logic write;
		logic [LANES-1:0] lanes;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asr_req_t;
endpackage

// ===== design/asr_wait.sv
`timescale 1ns/1ns
`default_nettype none
// Count down a load value; done is a level
module asr_wait #(
	parameter int W = 16
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic done
);
	logic [W-1:0] cnt;
	always_ff @(posedge SYS_CLK) begin
		if (!NRST)
			cnt <= '0;
		else if (load)
			cnt <= value;
		else if (cnt != '0)
			cnt <= cnt - 1'b1;
	end
	assign done = (cnt == '0);
endmodule
`default_nettype wire

// ===== verification/asr_sram_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------
// Memory model
// ----------
module asr_sram_model (
	input wire asr_pkg::asr_pins_t pins,
	input wire logic [15:0] host_dq,
	input wire logic [15:0] host_oe,
	output logic [15:0] dq
);
	logic [15:0] mem [0:65535];
	logic [15:0] pat = 16'h5A3C;
	logic [15:0] rdat;
	logic [1:0] lane_on;
	wire [1:0] lane_n = {pins.upper_lane_enable_n, pins.lower_lane_enable_n};
	wire rd = !pins.select_n && !pins.out_drive_n && pins.write_strobe_n;
	wire wr = !pins.select_n && !pins.write_strobe_n;
	// Floating pins keep changing
	always #5 pat = ~pat;
	assign #10 rdat = mem[pins.addr];
	assign #5 lane_on = rd ? ~lane_n : 2'h0;
	// Stored only within the overlap
	always @* begin
		if (wr && !lane_n[0]) mem[pins.addr][7:0] = host_dq[7:0];
		if (wr && !lane_n[1]) mem[pins.addr][15:8] = host_dq[15:8];
	end
	always @* begin
		for (int i = 0; i < 16; i++) begin
			dq[i] = host_oe[i] ? host_dq[i] : (lane_on[i/8] ? rdat[i] : pat[i]);
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic SYS_CLK = 1'b0;
	logic NRST = 1'b0;
	logic REQ_VALID = 1'b0;
	logic RETAIN_REQ = 1'b0;
	asr_pkg::asr_req_t REQ = '0;
	logic REQ_READY, RSP_VALID, RETAIN_OK, POWER_READY;
	logic [15:0] RSP_DATA, DQ_I, DQ_O, DQ_OE;
	asr_pkg::asr_pins_t PINS;
	logic [15:0] shadow [2];
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	always #5 SYS_CLK = ~SYS_CLK;
	asr_host #(.POWER_UP_CYCLES(20)) DUT (.SYS_CLK(SYS_CLK), .NRST(NRST),
		.REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID),
		.RSP_DATA(RSP_DATA), .RETAIN_REQ(RETAIN_REQ), .RETAIN_OK(RETAIN_OK),
		.POWER_READY(POWER_READY), .PINS(PINS), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE(DQ_OE));
	asr_sram_model mem_model (.pins(PINS), .host_dq(DQ_O), .host_oe(DQ_OE), .dq(DQ_I));
	task automatic results;
		if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick;
		@(posedge SYS_CLK);
		#1;
	endtask
	task automatic send(input logic w, input logic [1:0] ln, input logic [15:0] a,
		input logic [15:0] d);
		for (int k = 0; k < 50 && REQ_READY !== 1'b1; k++) tick;
		REQ = '{w, ln, a, d};
		REQ_VALID = 1'b1;
		tick;
		REQ_VALID = 1'b0;
	endtask
	task automatic wr(input logic [1:0] ln, input logic [15:0] a, input logic [15:0] d);
		logic [15:0] m;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		send(1'b1, ln, a, d);
		cmp("write strobes", {13'h0, 1'b0, ~ln}, {13'h0, PINS[18:16]});
		cmp("write select", 16'h0000, {15'h0, PINS.select_n});
		cmp("write drive", m, DQ_OE);
		cmp("write data", d & m, DQ_O & m);
		cmp("write addr", a, PINS.addr);
		tick;
		cmp("write end", 16'h0003, {14'h0, PINS.select_n, PINS.write_strobe_n});
		cmp("data hold", m, DQ_OE);
		cmp("addr hold", a, PINS.addr);
		repeat (2) tick;
		cmp("ready", 16'h0001, {15'h0, REQ_READY});
		shadow[a[0]] = (shadow[a[0]] & ~m) | (d & m);
	endtask
	task automatic rd(input logic [1:0] ln, input logic [15:0] a);
		logic [15:0] m;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		send(1'b0, ln, a, 16'h0000);
		cmp("read strobes", {11'h0, 3'h1, ~ln}, {11'h0, PINS[20:16]});
		cmp("read addr", a, PINS.addr);
		repeat (4) tick;
		cmp("read valid", 16'h0001, {15'h0, RSP_VALID});
		cmp("read data", shadow[a[0]] & m, RSP_DATA);
	endtask
	task automatic t_ignore;
		REQ = '{1'b1, 2'h0, 16'h0000, 16'hFFFF};
		REQ_VALID = 1'b1;
		repeat (3) tick;
		cmp("no lane select", 16'h0001, {15'h0, PINS.select_n});
		cmp("no lane ready", 16'h0001, {15'h0, REQ_READY});
		REQ_VALID = 1'b0;
	endtask
	task automatic t_retain;
		RETAIN_REQ = 1'b1;
		repeat (3) tick;
		cmp("retain", 16'h0003, {14'h0, RETAIN_OK, PINS.select_n});
		cmp("retain busy", 16'h0000, {15'h0, REQ_READY});
		RETAIN_REQ = 1'b0;
		tick;
	endtask
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			results;
		end
	end
	initial begin
		repeat (6) tick;
		cmp("reset strobes", 16'h001F, {11'h0, PINS[20:16]});
		cmp("reset drive", 16'h0000, DQ_OE);
		NRST = 1'b1;
		tick;
		cmp("power wait", 16'h0000, {14'h0, POWER_READY, REQ_READY});
		repeat (25) tick;
		cmp("power done", 16'h0003, {14'h0, POWER_READY, REQ_READY});
		wr(2'h3, 16'h0000, 16'hA55A);
		wr(2'h3, 16'hFFFF, 16'h0FF0);
		rd(2'h3, 16'h0000);
		wr(2'h1, 16'h0000, 16'h77C3);
		rd(2'h1, 16'h0000);
		wr(2'h2, 16'hFFFF, 16'h3C00);
		rd(2'h2, 16'hFFFF);
		rd(2'h3, 16'hFFFF);
		t_ignore;
		t_retain;
		rd(2'h3, 16'h0000);
		results;
	end
endmodule
`default_nettype wire
